// ### logic/twsr_regs.sv
// Status flags, interrupt mask and holding registers of a two-wire controller.
// Assumes the bit shifter runs on clk and hands over events as one-cycle strobes;
// only the serial clock level comes from outside and is synchronised here.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module twsr_regs
  import twsr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        master_mode,
  input  wire logic        slave_mode,
  input  wire logic        master_enable_cmd,
  input  wire logic [6:0]  own_slave_address,
  input  wire logic        frame_start,
  input  wire logic        stop_sent,
  input  wire logic        stop_seen,
  input  wire logic        addr_valid,
  input  wire logic [6:0]  addr_byte,
  input  wire logic        addr_read,
  input  wire logic        tx_taken,
  input  wire logic        tx_answered,
  input  wire logic        nack_seen,
  input  wire logic        arb_lost,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_in,
  input  wire logic        scl_in,
  output logic [7:0]       tx_byte,
  output logic             tx_full,
  output logic             tx_stop,
  output logic             rx_ack,
  output logic             scl_oe,
  output logic             scl_out,
  output logic             irq
);
  import twsr_pkg::*;

  logic [31:0] rdata_q;
  logic        pready_q;
  logic        perr_q;
  logic [11:0] mask_q;
  logic [11:0] flags_q;
  logic [7:0]  rx_byte_q;
  logic [7:0]  tx_byte_q;
  logic        tx_full_q;
  logic        tx_stop_q;
  logic        rx_ack_q;
  logic        stretch_q;
  logic        irq_q;
  logic [2:0]  scl_sync_q;
  logic        scl_low_q;
  logic        access;
  logic        mapped;
  logic        wr_tx;
  logic        rd_rx;
  logic        rd_st;
  logic        match;
  logic        gcall;
  logic [11:0] set_v;
  logic [11:0] clr_v;

  // Decode; side effects happen only at the edge where the master sees pready.
  assign access = psel & penable & pready_q;
  assign mapped = (paddr == OFS_STATUS) | (paddr == OFS_IRQ_SET) | (paddr == OFS_IRQ_CLR)
                | (paddr == OFS_IRQ_MASK) | (paddr == OFS_RX_HOLD) | (paddr == OFS_TX_HOLD);
  assign wr_tx  = access & pwrite & (paddr == OFS_TX_HOLD);
  assign rd_rx  = access & ~pwrite & (paddr == OFS_RX_HOLD);
  assign rd_st  = access & ~pwrite & (paddr == OFS_STATUS);
  assign gcall  = addr_valid & slave_mode & (addr_byte == GEN_CALL_ADDR);
  assign match  = addr_valid & slave_mode & ((addr_byte == own_slave_address) | gcall);

  // APB answer: one wait state, data and error registered with pready.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready_q <= 1'b0;
      perr_q   <= 1'b0;
      rdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= psel & penable & ~pready_q;
      perr_q   <= psel & penable & ~pready_q & ~mapped;
      if (psel & penable & ~pready_q & ~pwrite)
      begin
        case (paddr)
          OFS_STATUS:   rdata_q <= {20'h00000, flags_q};
          OFS_IRQ_MASK: rdata_q <= {20'h00000, mask_q};
          OFS_RX_HOLD:  rdata_q <= {24'h000000, rx_byte_q};
          OFS_TX_HOLD:  rdata_q <= {24'h000000, tx_byte_q};
          default:      rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Interrupt mask: write-one-to-set and write-one-to-clear views of one register.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      mask_q <= MASK_RESET;
    else if (access & pwrite & (paddr == OFS_IRQ_SET))
      mask_q <= mask_q | (pwdata[11:0] & MASK_BITS);
    else if (access & pwrite & (paddr == OFS_IRQ_CLR))
      mask_q <= mask_q & ~pwdata[11:0];
  end

  // Data holding registers.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_byte_q <= BYTE_RESET;
      tx_byte_q <= BYTE_RESET;
    end
    else
    begin
      if (rx_valid)
        rx_byte_q <= rx_in;
      if (wr_tx)
        tx_byte_q <= pwdata[7:0];
    end
  end

  // Serial clock level: three stages, low counts once the last two agree.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      scl_sync_q <= 3'b111;
      scl_low_q  <= 1'b0;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      if (scl_sync_q[1] == scl_sync_q[2])
        scl_low_q <= ~scl_sync_q[2];
    end
  end

  // Set and clear terms for the sticky and automatic flags.
  always_comb
  begin
    set_v = 12'h000;
    clr_v = 12'h000;
    set_v[B_DONE] = stop_sent | stop_seen | (master_mode & (nack_seen | arb_lost));
    clr_v[B_DONE] = frame_start;
    set_v[B_TXE]  = master_enable_cmd
                  | (master_mode & (tx_taken | nack_seen))
                  | (slave_mode & tx_answered);
    clr_v[B_TXE]  = wr_tx;
    set_v[B_RXF]  = rx_valid;
    clr_v[B_RXF]  = rd_rx;
    set_v[B_OVR]  = master_mode & rx_valid & flags_q[B_RXF];
    clr_v[B_OVR]  = rd_st & rdata_q[B_OVR] & rdata_q[B_DONE];
    set_v[B_NACK] = nack_seen & (master_mode | (slave_mode & flags_q[B_DIR]));
    clr_v[B_NACK] = rd_st & rdata_q[B_NACK];
    set_v[B_ARB]  = master_mode & arb_lost;
    clr_v[B_ARB]  = rd_st & rdata_q[B_ARB];
    set_v[B_GC]   = gcall;
    clr_v[B_GC]   = rd_st & rdata_q[B_GC];
    set_v[B_ADDR] = match;
    clr_v[B_ADDR] = nack_seen | stop_seen;
    set_v[B_END]  = flags_q[B_ADDR] & ~match & (nack_seen | stop_seen);
    clr_v[B_END]  = rd_st & rdata_q[B_END];
  end

  // Flags: set wins over any clear in the same cycle, so no event is lost.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flags_q         <= 12'h000;
      flags_q[B_DONE] <= 1'b1;
      flags_q[B_DIR]  <= 1'b1;
    end
    else
    begin
      flags_q <= set_v | (flags_q & ~clr_v);
      if (match)
        flags_q[B_DIR] <= addr_read;
      flags_q[B_WAIT] <= stretch_q & scl_low_q;
      flags_q[7]      <= 1'b0;
    end
  end

  // Slave-side line control and the handoff to the shifter.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stretch_q <= 1'b0;
      tx_stop_q <= 1'b0;
      rx_ack_q  <= 1'b0;
      tx_full_q <= 1'b0;
    end
    else
    begin
      stretch_q <= slave_mode & flags_q[B_ADDR]
                 & ((flags_q[B_DIR] & flags_q[B_TXE] & ~flags_q[B_NACK])
                 | (~flags_q[B_DIR] & flags_q[B_RXF]));
      tx_stop_q <= slave_mode & flags_q[B_TXE] & flags_q[B_NACK];
      rx_ack_q  <= slave_mode & flags_q[B_ADDR] & ~flags_q[B_DIR];
      tx_full_q <= ~set_v[B_TXE] & (clr_v[B_TXE] | ~flags_q[B_TXE]);
    end
  end

  // Interrupt request from flags gated by the mask.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_q <= 1'b0;
    else
      irq_q <= |(flags_q & mask_q & MASK_BITS);
  end

  assign prdata  = rdata_q;
  assign pready  = pready_q;
  assign pslverr = perr_q;
  assign tx_byte = tx_byte_q;
  assign tx_full = tx_full_q;
  assign tx_stop = tx_stop_q;
  assign rx_ack  = rx_ack_q;
  assign scl_oe  = stretch_q;
  assign scl_out = 1'b0;
  assign irq     = irq_q;

  a_irq_follow: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 (irq == |($past(flags_q) & $past(mask_q))))
    else $error("irq does not follow flags and mask");
  a_mask_set: assert property (@(posedge clk) disable iff (sys_rst)
    (access & pwrite & (paddr == OFS_IRQ_SET)) |=> ((mask_q & ($past(pwdata[11:0]) & MASK_BITS))
    == ($past(pwdata[11:0]) & MASK_BITS)))
    else $error("enable write missed a mask bit");
  a_mask_clr: assert property (@(posedge clk) disable iff (sys_rst)
    (access & pwrite & (paddr == OFS_IRQ_CLR)) |=> ((mask_q & $past(pwdata[11:0])) == 12'h000))
    else $error("disable write left a mask bit");
  a_txe_write: assert property (@(posedge clk) disable iff (sys_rst)
    (wr_tx & ~set_v[B_TXE]) |=> (~flags_q[B_TXE] & tx_full))
    else $error("holding write did not clear empty flag");
  a_txe_menable: assert property (@(posedge clk) disable iff (sys_rst)
    master_enable_cmd |=> flags_q[B_TXE])
    else $error("master enable did not set empty flag");
  a_nack_done: assert property (@(posedge clk) disable iff (sys_rst)
    (master_mode & nack_seen) |=> (flags_q[B_NACK] & flags_q[B_DONE] & flags_q[B_TXE]))
    else $error("nack did not set flags together");
  a_arb_done: assert property (@(posedge clk) disable iff (sys_rst)
    (master_mode & arb_lost) |=> (flags_q[B_ARB] & flags_q[B_DONE]))
    else $error("arbitration loss flags missing");
  a_rx_full: assert property (@(posedge clk) disable iff (sys_rst)
    rx_valid |=> (flags_q[B_RXF] & (rx_byte_q == $past(rx_in))))
    else $error("received byte not held");
  a_ovr_set: assert property (@(posedge clk) disable iff (sys_rst)
    (master_mode & rx_valid & flags_q[B_RXF]) |=> flags_q[B_OVR])
    else $error("overrun not flagged");
  a_addr_match: assert property (@(posedge clk) disable iff (sys_rst)
    match |=> (flags_q[B_ADDR] & (flags_q[B_DIR] == $past(addr_read))))
    else $error("address match flags wrong");
  a_end_access: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(flags_q[B_ADDR]) |-> flags_q[B_END])
    else $error("end of access not flagged");
  a_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_st & gcall) |=> flags_q[B_GC])
    else $error("general call lost on status read");
  a_stop_tx: assert property (@(posedge clk) disable iff (sys_rst)
    (slave_mode & flags_q[B_TXE] & flags_q[B_NACK]) |=> tx_stop)
    else $error("slave transmit not stopped");

  // A new frame drops transfer_done unless a finishing event lands in the same cycle.
  a_done_frame: assert property (@(posedge clk) disable iff (sys_rst)
    (frame_start & ~set_v[B_DONE]) |=> ~flags_q[B_DONE])
    else $error("frame start left transfer done high");
  // The stop strobe from the shifter marks the frame as finished.
  a_done_stop: assert property (@(posedge clk) disable iff (sys_rst)
    stop_sent |=> flags_q[B_DONE])
    else $error("stop sent did not set transfer done");
  // Reading the receive holding register empties it.
  a_rxf_read: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_rx & ~rx_valid) |=> ~flags_q[B_RXF])
    else $error("receive read left the full flag");
  // The shifter taking the held byte frees the holding register in master mode.
  a_txe_taken: assert property (@(posedge clk) disable iff (sys_rst)
    (master_mode & tx_taken) |=> flags_q[B_TXE])
    else $error("shifter load did not set empty flag");
  // In slave mode the holding register frees once the byte was answered.
  a_txe_answer: assert property (@(posedge clk) disable iff (sys_rst)
    (slave_mode & tx_answered) |=> flags_q[B_TXE])
    else $error("answered byte did not set empty flag");
  // A remote master refusing a byte of a slave read is flagged.
  a_nack_slave: assert property (@(posedge clk) disable iff (sys_rst)
    (slave_mode & flags_q[B_DIR] & nack_seen) |=> flags_q[B_NACK])
    else $error("slave read nack not flagged");
  // A general call is recorded and also counts as being addressed.
  a_gc_set: assert property (@(posedge clk) disable iff (sys_rst)
    gcall |=> (flags_q[B_GC] & flags_q[B_ADDR]))
    else $error("general call not flagged");
  // The addressed flag drops by itself on a missing ack or a stop.
  a_addr_drop: assert property (@(posedge clk) disable iff (sys_rst)
    (flags_q[B_ADDR] & ~match & (nack_seen | stop_seen)) |=> ~flags_q[B_ADDR])
    else $error("slave addressed flag did not drop");
  // Bytes written to us as a slave are always acknowledged.
  a_ack_write: assert property (@(posedge clk) disable iff (sys_rst)
    (slave_mode & flags_q[B_ADDR] & ~flags_q[B_DIR]) |=> rx_ack)
    else $error("slave write byte not acknowledged");
  // The wait flag mirrors the stretch request seen with the line held low.
  a_wait_flag: assert property (@(posedge clk) disable iff (sys_rst)
    flags_q[B_WAIT] == ($past(stretch_q) & $past(scl_low_q)))
    else $error("clock wait flag out of step");
  // An unread received byte stretches the clock of a slave write.
  a_stretch_read: assert property (@(posedge clk) disable iff (sys_rst)
    (slave_mode & flags_q[B_ADDR] & ~flags_q[B_DIR] & flags_q[B_RXF]) |=> scl_oe)
    else $error("full receive register did not stretch");
  // Upper bits of the receive holding view always read zero.
  a_rx_zero: assert property (@(posedge clk) disable iff (sys_rst)
    (pready & ~pwrite & (paddr == OFS_RX_HOLD)) |-> (prdata[31:8] == 24'h000000))
    else $error("receive view upper bits not zero");
  // Overrun clears on a status read only when that read also showed done.
  a_ovr_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_st & rdata_q[B_OVR] & rdata_q[B_DONE] & ~set_v[B_OVR]) |=> ~flags_q[B_OVR])
    else $error("overrun not cleared by status read");
  // The transmit holding register keeps the written byte.
  a_tx_hold: assert property (@(posedge clk) disable iff (sys_rst)
    wr_tx |=> (tx_byte == $past(pwdata[7:0])))
    else $error("transmit byte not held");
  // Arbitration loss clears on the read that reported it.
  a_arb_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_st & rdata_q[B_ARB] & ~set_v[B_ARB]) |=> ~flags_q[B_ARB])
    else $error("arbitration flag not cleared by read");
  // Not-acknowledged clears on the read that reported it.
  a_nack_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_st & rdata_q[B_NACK] & ~set_v[B_NACK]) |=> ~flags_q[B_NACK])
    else $error("nack flag not cleared by read");
  // General call clears on the read that reported it.
  a_gc_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_st & rdata_q[B_GC] & ~set_v[B_GC]) |=> ~flags_q[B_GC])
    else $error("general call flag not cleared by read");
  // End of access clears on the read that reported it.
  a_end_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (rd_st & rdata_q[B_END] & ~set_v[B_END]) |=> ~flags_q[B_END])
    else $error("end of access flag not cleared by read");
  // With every source masked off the request must stay quiet.
  a_irq_off: assert property (@(posedge clk) disable iff (sys_rst)
    (mask_q == 12'h000) |=> ~irq)
    else $error("irq raised with empty mask");
  // The direction bit only moves when an address is matched.
  a_dir_hold: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(flags_q[B_DIR]) |-> $past(match))
    else $error("direction bit changed without address");
  // The mask view returns the mask as it stood when the read was taken.
  a_mask_view: assert property (@(posedge clk) disable iff (sys_rst)
    (pready & ~pwrite & (paddr == OFS_IRQ_MASK)) |-> (prdata == {20'h00000, $past(mask_q)}))
    else $error("mask view differs from mask");
  // The status view returns the flags as they stood when the read was taken.
  a_status_view: assert property (@(posedge clk) disable iff (sys_rst)
    (pready & ~pwrite & (paddr == OFS_STATUS)) |-> (prdata == {20'h00000, $past(flags_q)}))
    else $error("status view differs from flags");

  c_read_status: cover property (@(posedge clk) disable iff (sys_rst) rd_st ##1 1'b1);
  c_slave_access: cover property (@(posedge clk) disable iff (sys_rst) match ##[1:50] stop_seen);
  c_stretch: cover property (@(posedge clk) disable iff (sys_rst) flags_q[B_WAIT]);
  c_irq: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq));
  c_overrun: cover property (@(posedge clk) disable iff (sys_rst) $rose(flags_q[B_OVR]));
endmodule
`default_nettype wire

// ### logic/twsr_pkg.sv
// Constants of the two-wire status, mask and holding-register block.
// Assumes a 32-bit APB master and a 100 MHz system clock.
// Contract
// - Master mode: a transmit-holding write clears tx_holding_empty.
// - Master mode: shifter load or missing ack sets tx_holding_empty.
// - The master_enable_cmd strobe sets tx_holding_empty.
// - Slave mode: tx_holding_empty stays low until the byte is sent and answered.
// - Slave mode: empty holding plus missing ack stops further transmission.
// - Slave read: missing master ack sets not-acknowledged; status read clears it.
// - Slave write access: every received data byte is acknowledged.
// - slave_dir_read is 1 for master read, 0 for master write.
// - Own address match raises slave_addressed until missing ack or stop.
// - Slave mode: general call sets general_call_seen; status read clears it.
// - Master mode: reload while rx full sets overrun; read clears it if done.
// - Master mode: missing slave ack sets not-acknowledged with transfer_done.
// - Master mode: lost arbitration sets the flag with transfer_done.
// - Slave mode: unserved holding registers stretch the clock and raise clock_wait_flag.
// - Falling slave_addressed sets slave_access_end; status read clears it.
// - Writing 1 to enable-set turns a mask bit on; 0 does nothing.
// - Writing 1 to enable-clear turns a mask bit off; 0 does nothing.
// - Mask view reads 1 per enabled source and resets to zero.
// - Enable, disable and mask share the status bit layout.
// - Receive holding shows the last byte on bits 7..0, upper zero.
// - Transmit holding keeps the next byte to send in bits 7..0.
// - Master mode: transfer_done low in a frame, high after stop sent.
// - rx_holding_full rises on byte arrival and falls on receive read.
package twsr_pkg;
  localparam logic [7:0]  OFS_STATUS   = 8'h00;
  localparam logic [7:0]  OFS_IRQ_SET  = 8'h04;
  localparam logic [7:0]  OFS_IRQ_CLR  = 8'h08;
  localparam logic [7:0]  OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0]  OFS_RX_HOLD  = 8'h10;
  localparam logic [7:0]  OFS_TX_HOLD  = 8'h14;
  localparam int          B_DONE  = 0;
  localparam int          B_RXF   = 1;
  localparam int          B_TXE   = 2;
  localparam int          B_DIR   = 3;
  localparam int          B_ADDR  = 4;
  localparam int          B_GC    = 5;
  localparam int          B_OVR   = 6;
  localparam int          B_NACK  = 8;
  localparam int          B_ARB   = 9;
  localparam int          B_WAIT  = 10;
  localparam int          B_END   = 11;
  localparam logic [11:0] MASK_BITS   = 12'hF77;
  localparam logic [11:0] MASK_RESET  = 12'h000;
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [6:0]  GEN_CALL_ADDR = 7'h00;
endpackage

// ### tb/twsr_far_model.sv
// Far-side model: bit shifter and remote bus parties as the status block sees them.
// Assumes the bench clock; every event strobe is one clk cycle wide.
`timescale 1ns/1ps
`default_nettype none
module twsr_far_model
(
  input  wire logic       clk,
  input  wire logic       scl_oe,
  output logic [9:0]      ev,
  output logic [7:0]      dat,
  output logic            scl_in
);
  logic run;
  logic gen;
  // Quiet bus at time zero; the pull-up keeps the clock line high.
  initial
  begin
    ev = '0;
    dat = '0;
    run = 1'b0;
    gen = 1'b1;
  end
  // The remote clock toggles only inside frames and stands high between them.
  always #62.5 gen = run ? ~gen : 1'b1;
  // A wired-and line, so a local stretch pulls the level low whatever the remote drives.
  assign scl_in = gen & ~scl_oe;
  // One strobe for one cycle; afterwards the data lines show the inverted byte, not the old byte.
  task automatic pulse(input logic [9:0] m, input logic [7:0] d);
  begin
    @(posedge clk);
    ev <= m;
    dat <= d;
    @(posedge clk);
    ev <= '0;
    dat <= ~d;
  end
  endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the status, mask and holding registers.
// Assumes the far-side model drives all shifter strobes and the clock pin.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import twsr_pkg::*;
  typedef struct packed {logic [1:0] md; logic [9:0] ev; logic [7:0] d; logic [11:0] ex; logic [11:0] cr;} twsr_row_t;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic        pready;
  logic        pslverr;
  logic        slv;
  logic        master_mode = 1'b0;
  logic        slave_mode = 1'b0;
  logic [9:0]  ev;
  logic [7:0]  dat;
  logic        scl_in;
  logic [7:0]  tx_byte;
  logic        tx_full;
  logic        scl_out;
  logic        tx_stop;
  logic        rx_ack;
  logic        scl_oe;
  logic        irq;
  int          err_total = 0;
  int          checks = 0;
  // Master rows first, slave rows after; care masks skip bits the rules leave open.
  twsr_row_t rows [16] = '{
    '{2'd1, 10'h200, 8'h00, 12'h00D, 12'hFFF}, '{2'd1, 10'h001, 8'h00, 12'h00C, 12'hFFF},
    '{2'd1, 10'h100, 8'hA5, 12'h00E, 12'hFFF}, '{2'd1, 10'h100, 8'h5A, 12'h04E, 12'hFFF},
    '{2'd1, 10'h002, 8'h00, 12'h04F, 12'hFFF}, '{2'd1, 10'h001, 8'h00, 12'h00E, 12'hFFF},
    '{2'd1, 10'h040, 8'h00, 12'h10F, 12'hFFF}, '{2'd1, 10'h001, 8'h00, 12'h00E, 12'hFFF},
    '{2'd1, 10'h080, 8'h00, 12'h20F, 12'hFFF}, '{2'd2, 10'h001, 8'h00, 12'h004, 12'hB75},
    '{2'd2, 10'h008, 8'hAC, 12'h01C, 12'hB7D}, '{2'd2, 10'h040, 8'h00, 12'h904, 12'hB74},
    '{2'd2, 10'h008, 8'h2C, 12'h014, 12'hB7C}, '{2'd2, 10'h004, 8'h00, 12'h805, 12'hB75},
    '{2'd2, 10'h008, 8'h00, 12'h034, 12'hB7C}, '{2'd2, 10'h004, 8'h00, 12'h805, 12'hB75}};

  twsr_regs twsr_regs_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_mode(master_mode), .slave_mode(slave_mode), .master_enable_cmd(ev[9]),
    .own_slave_address(7'h2C), .frame_start(ev[0]), .stop_sent(ev[1]), .stop_seen(ev[2]),
    .addr_valid(ev[3]), .addr_byte(dat[6:0]), .addr_read(dat[7]), .tx_taken(ev[4]), .tx_answered(ev[5]),
    .nack_seen(ev[6]), .arb_lost(ev[7]), .rx_valid(ev[8]), .rx_in(dat), .scl_in(scl_in),
    .tx_byte(tx_byte), .tx_full(tx_full), .tx_stop(tx_stop), .rx_ack(rx_ack), .scl_oe(scl_oe), .scl_out(scl_out),
    .irq(irq));
  twsr_far_model far_inst (.clk(clk), .scl_oe(scl_oe), .ev(ev), .dat(dat), .scl_in(scl_in));

  // Free-running system clock.
  always #5 clk = ~clk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
  begin
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  end
  endtask
  // One APB transfer; the wait on pready is bounded so a dead slave cannot hang the run.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
  begin
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) err_total++;
    r = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] c);
  begin
    apb(1'b0, a, 32'h0);
    chk(r & c, e);
  end
  endtask
  task automatic summarize;
  begin
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask

  // Watchdog sized well above the few hundred cycles the sequence needs.
  initial
  begin
    #200us;
    err_total++;
    summarize();
  end
  // Main sequence: table rows, then hand-written cases, then a second reset.
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFS_STATUS, 32'h9, '1);
    foreach (rows[i])
    begin
      master_mode <= rows[i].md[0];
      slave_mode <= rows[i].md[1];
      far_inst.pulse(rows[i].ev, rows[i].d);
      rd(OFS_STATUS, {20'h0, rows[i].ex & rows[i].cr}, {20'hFFFFF, rows[i].cr});
      $display("row %0d done", i);
    end
    rd(OFS_RX_HOLD, 32'h5A, '1);
    rd(OFS_STATUS, 32'h0, 32'h2);
    master_mode <= 1'b1;
    slave_mode <= 1'b0;
    apb(1'b1, OFS_IRQ_SET, '1);
    rd(OFS_IRQ_MASK, 32'hF77, '1);
    apb(1'b1, OFS_IRQ_CLR, 32'h0F0);
    apb(1'b1, OFS_IRQ_SET, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    rd(OFS_IRQ_MASK, 32'hF07, '1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_IRQ_CLR, 32'hFFF);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h18, 32'h1);
    chk({31'h0, slv}, 32'h1);
    $display("mask test done");
    apb(1'b1, OFS_TX_HOLD, 32'h1C3);
    rd(OFS_TX_HOLD, 32'hC3, 32'hFF);
    rd(OFS_STATUS, 32'h0, 32'h4);
    chk({24'h0, tx_byte}, 32'hC3);
    chk({31'h0, tx_full}, 32'h1);
    far_inst.pulse(10'h010, 8'h00);
    rd(OFS_STATUS, 32'h4, 32'h4);
    chk({31'h0, tx_full}, 32'h0);
    $display("master tx test done");
    master_mode <= 1'b0;
    slave_mode <= 1'b1;
    far_inst.run = 1'b1;
    far_inst.pulse(10'h008, 8'h2C);
    far_inst.pulse(10'h100, 8'h11);
    far_inst.pulse(10'h100, 8'h22);
    repeat (40) @(posedge clk);
    chk({31'h0, rx_ack}, 32'h1);
    chk({31'h0, scl_oe}, 32'h1);
    chk({31'h0, scl_out}, 32'h0);
    rd(OFS_STATUS, 32'h400, 32'h400);
    rd(OFS_RX_HOLD, 32'h22, '1);
    repeat (40) @(posedge clk);
    chk({31'h0, scl_oe}, 32'h0);
    far_inst.pulse(10'h004, 8'h00);
    far_inst.run = 1'b0;
    rd(OFS_STATUS, 32'h805, 32'hFFF);
    far_inst.pulse(10'h008, 8'hAC);
    apb(1'b1, OFS_TX_HOLD, 32'h3C);
    rd(OFS_STATUS, 32'h0, 32'h4);
    far_inst.pulse(10'h020, 8'h00);
    rd(OFS_STATUS, 32'h4, 32'h4);
    far_inst.pulse(10'h040, 8'h00);
    repeat (2) @(posedge clk);
    chk({31'h0, tx_stop}, 32'h1);
    $display("slave test done");
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFS_STATUS, 32'h9, '1);
    rd(OFS_IRQ_MASK, 32'h0, '1);
    rd(OFS_RX_HOLD, 32'h0, '1);
    rd(OFS_TX_HOLD, 32'h0, '1);
    $display("reset test done");
    summarize();
  end
endmodule
`default_nettype wire
